// File: dv/raf_host_model.sv
// Host side of the register port: one-cycle strobes, negedge driven
module raf_host_model
  import raf_pkg::*;
(
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus starts all zero; after each access the tasks leave an inverted address, and a write also leaves inverted data
  initial
  begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // Write: strobe held over exactly one rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read: data is taken by the bench monitor one cycle later
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// File: dv/raf_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import raf_pkg::*;

  logic clk, rst, backup_lost, reg_wr, reg_rd, second_tick, time_written;
  logic watchdog_timeout, supply_fail, osc_enable, osc_running;
  logic watchdog_int_en, alarm_int_en, supply_int_en;
  logic polarity_select, pulse_level_select, freeze_counters;
  logic counters_load, hold_snapshot, cal_output_en, int_out, int_oe, rd_d;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] cur_second, cur_minute, cur_hour, cur_date;
  logic [7:0] exp_q[$];
  int failures, compares, n;
  int seed = 32'hd722cecf;

  ////////////////////////////////////////////////////////////
  // Short counts keep the pulse and start-up check cheap
  raf_regs #(.PULSE_CYCLES(40), .OSC_CHECK_CYCLES(20)) i_dut (
    .clk, .rst, .backup_lost, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .watchdog_timeout, .supply_fail, .second_tick,
    .cur_second, .cur_minute, .cur_hour, .cur_date, .time_written,
    .osc_enable, .osc_running, .watchdog_int_en, .alarm_int_en,
    .supply_int_en, .polarity_select, .pulse_level_select,
    .freeze_counters, .counters_load, .hold_snapshot, .cal_output_en,
    .int_out, .int_oe);

  raf_host_model i_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  // Clock at 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task report_and_stop;
    // A read that never answered is a mismatch too
    if (exp_q.size() != 0)
      failures++;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Note the expected byte, then let the host issue the read
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // Expected {out, oe}: open-drain mode only enables when active
  function automatic logic [7:0] pin(input logic p, input logic act);
    return p ? {6'h00, act, 1'b1} : {6'h00, 1'b0, act};
  endfunction

  ////////////////////////////////////////////////////////////
  // Read data settles one cycle after the strobe and is then compared
  always @(posedge clk)
    rd_d <= reg_rd && !rst;

  always @(negedge clk)
  begin
    if (rd_d && exp_q.size() == 0)
      check("read queue", 8'h01, 8'h00);
    else if (rd_d)
      check("reg_rdata", reg_rdata, exp_q.pop_front());
  end

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge clk);
    failures++;
    report_and_stop;
  end

  initial
  begin
    {rst, backup_lost, osc_enable, osc_running} = 4'hf;
    {watchdog_timeout, supply_fail, second_tick, time_written} = 4'h0;
    {watchdog_int_en, alarm_int_en, supply_int_en} = 3'h0;
    {polarity_select, pulse_level_select} = 2'h2;
    {cur_second, cur_minute, cur_hour, cur_date} = 28'h0;
    cyc(20);
    rst = 1'b0;
    check("freeze", {7'h00, freeze_counters}, 8'h00);
    rd(ADDR_FLAGS, 8'h10);
    rd(ADDR_CENT, CENT_RST);
    rd(ADDR_ASEC, ALARM_RST);
    rd(ADDR_ADATE, ALARM_RST);
    rd(4'h9, READ_ZERO);
    $display("test reset values done");
    // Locked writes, then the delayed fail flag clear
    i_host.wr(ADDR_CENT, 8'h42);
    rd(ADDR_CENT, 8'h00);
    i_host.wr(ADDR_FLAGS, 8'h12);
    rd(ADDR_FLAGS, 8'h12);
    i_host.wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h12);
    cyc(3490);
    rd(ADDR_FLAGS, 8'h12);
    cyc(8);
    rd(ADDR_FLAGS, 8'h02);
    $display("test fail flag clear done");
    i_host.wr(ADDR_CENT, 8'h99);
    rd(ADDR_CENT, 8'h99);
    i_host.wr(ADDR_CENT, 8'h9a);
    i_host.wr(ADDR_CENT, 8'ha0);
    rd(ADDR_CENT, 8'h99);
    $display("test centuries done");
    // Alarm: seconds compared, others ignored except minutes
    alarm_int_en = 1'b1;
    i_host.wr(ADDR_ASEC, 8'h15);
    i_host.wr(ADDR_AMIN, 8'h30);
    i_host.wr(ADDR_AHOUR, 8'h80);
    i_host.wr(ADDR_ADATE, 8'h80);
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        i_host.wr(ADDR_AMIN, 8'hb1);
      cur_second = (k == 2) ? 7'h16 : 7'h15;
      cur_minute = (k == 1) ? 7'h31 : 7'h30;
      cur_hour = 7'($random(seed));
      cur_date = 7'($random(seed));
      pulse(second_tick);
      rd(ADDR_FLAGS, (k == 0 || k == 3) ? 8'h42 : 8'h02);
    end
    rd(ADDR_AMIN, 8'hb1);
    rd(ADDR_AHOUR, 8'h80);
    $display("test alarm done");
    // Both polarities, level then pulse mode
    {watchdog_int_en, supply_int_en} = 2'h3;
    for (int p = 0; p < 2; p++)
    begin
      polarity_select = p[0];
      pulse_level_select = 1'b0;
      pulse(watchdog_timeout);
      cyc(1);
      check("pin", {6'h00, int_out, int_oe}, pin(p[0], 1'b1));
      rd(ADDR_FLAGS, 8'h82);
      check("pin", {6'h00, int_out, int_oe}, pin(p[0], 1'b0));
      pulse_level_select = 1'b1;
      pulse(supply_fail);
      cyc(30);
      check("pin", {6'h00, int_out, int_oe}, pin(p[0], 1'b1));
      cyc(15);
      check("pin", {6'h00, int_out, int_oe}, pin(p[0], 1'b0));
      rd(ADDR_FLAGS, 8'h22);
    end
    $display("test interrupt pin done");
    i_host.wr(ADDR_FLAGS, 8'h07);
    check("hold cal", {6'h00, cal_output_en, hold_snapshot}, 8'h03);
    rd(ADDR_FLAGS, 8'h07);
    $display("test hold done");
    // Changed time is loaded about 3500 cycles after the write enable drops
    pulse(time_written);
    i_host.wr(ADDR_FLAGS, 8'h00);
    check("freeze", {7'h00, freeze_counters}, 8'h01);
    n = 0;
    while (counters_load !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      failures++;
      report_and_stop;
    end
    check("xfer", {7'h00, (n >= 3495 && n <= 3505)}, 8'h01);
    cyc(2);
    check("freeze", {7'h00, freeze_counters}, 8'h00);
    // Unchanged time: the enable drop must not load the counters
    i_host.wr(ADDR_FLAGS, 8'h02);
    i_host.wr(ADDR_FLAGS, 8'h00);
    n = 0;
    repeat (3510)
    begin
      @(negedge clk);
      if (counters_load !== 1'b0)
        n++;
    end
    check("no load", n[7:0], 8'h00);
    $display("test transfer done");
    // Stopped oscillator at start-up raises the fail flag
    osc_running = 1'b0;
    @(negedge clk);
    rst = 1'b1;
    backup_lost = 1'b0;
    cyc(20);
    rst = 1'b0;
    cyc(25);
    rd(ADDR_FLAGS, 8'h10);
    // Enable is clear again, so the alarm write must be refused
    i_host.wr(ADDR_ASEC, 8'h11);
    rd(ADDR_ASEC, ALARM_RST);
    // All fields ignored after reset: any tick is a match
    pulse(second_tick);
    rd(ADDR_FLAGS, 8'h50);
    $display("test start-up check done");
    cyc(2);
    report_and_stop;
  end
endmodule

// File: hw/raf_field_match.sv
// One alarm field: hit when ignored or when the value equals the time
module raf_field_match
  import raf_pkg::*;
(
  input wire logic [7:0] alarm_val,
  input wire logic [6:0] cur_val,
  output logic hit
);

  // Ignore bit set means this field never blocks a match
  assign hit = alarm_val[IGNORE_BIT] | (alarm_val[6:0] == cur_val);

endmodule

// File: hw/raf_pkg.sv
package raf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned PULSE_MS = 200;
  localparam int unsigned OSC_CHECK_MS = 5;
  localparam int unsigned XFER_US = 350;
  // Cycle counts; every division rounds down, all exact at 10 MHz
  localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_CHECK_CYC = OSC_CHECK_MS * (CLK_HZ / 1000);
  localparam int unsigned XFER_CYC = XFER_US * (CLK_HZ / 1000) / 1000;
  localparam int unsigned PULSE_W = 21;
  localparam int unsigned POR_W = 16;
  localparam int unsigned XFER_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_CENT = 4'h1;
  localparam logic [3:0] ADDR_ASEC = 4'h2;
  localparam logic [3:0] ADDR_AMIN = 4'h3;
  localparam logic [3:0] ADDR_AHOUR = 4'h4;
  localparam logic [3:0] ADDR_ADATE = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned WDF_BIT = 7;
  localparam int unsigned AF_BIT = 6;
  localparam int unsigned PF_BIT = 5;
  localparam int unsigned OSCILLATOR_FAIL_FLAG_BIT = 4;
  localparam int unsigned CAL_BIT = 2;
  localparam int unsigned WEN_BIT = 1;
  localparam int unsigned HOLD_BIT = 0;
  localparam int unsigned IGNORE_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [7:0] ALARM_RST = 8'h80;
  localparam logic [7:0] CENT_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] BCD_MAX = 4'h9;

endpackage

// File: hw/raf_regs.sv
// Contract
// - Polarity bit: high drive or open-drain low
// - Pulse mode 200 ms, level until flags read
// - Alarm field bit 7 set ignores field
// - Power-up: oscillator enabled but not running sets fail flag
// - Fail flag kept; only host write clears
// - Fail flag clear shows after transfer delay
// - Write-enable bit freezes counters, opens writes
// - Clearing write-enable loads counters within delay, only if time was written
// - Write-enable bit zero after power-up
// - Hold bit keeps time stable while reading
// - Event flags set by events, cleared on read
// - Flags register powers up as zero except the fail flag, which is kept or set if backup was lost
module raf_regs
  import raf_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned OSC_CHECK_CYCLES = OSC_CHECK_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic backup_lost,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic watchdog_timeout,
  input wire logic supply_fail,
  input wire logic second_tick,
  input wire logic [6:0] cur_second,
  input wire logic [6:0] cur_minute,
  input wire logic [6:0] cur_hour,
  input wire logic [6:0] cur_date,
  input wire logic time_written,
  input wire logic osc_enable,
  input wire logic osc_running,
  input wire logic watchdog_int_en,
  input wire logic alarm_int_en,
  input wire logic supply_int_en,
  input wire logic polarity_select,
  input wire logic pulse_level_select,
  output logic freeze_counters,
  output logic counters_load,
  output logic hold_snapshot,
  output logic cal_output_en,
  output logic int_out,
  output logic int_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] asec;
    logic [7:0] amin;
    logic [7:0] ahour;
    logic [7:0] adate;
    logic watchdog_expired_flag;
    logic af;
    logic pf;
    logic oscillator_fail_flag;
    logic cal;
    logic wr_en;
    logic rd_hold;
    logic [7:0] rdata;
    logic pulse_on;
    logic [PULSE_W-1:0] pulse_cnt;
    logic por_done;
    logic [POR_W-1:0] por_cnt;
    logic oclr_busy;
    logic [XFER_W-1:0] oclr_cnt;
    logic xfer_busy;
    logic [XFER_W-1:0] xfer_cnt;
    logic dirty;
    logic load;
  } raf_state_s;

  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_CYCLES - 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(OSC_CHECK_CYCLES - 1);
  localparam logic [XFER_W-1:0] XFER_LAST = XFER_W'(XFER_CYC - 1);

  raf_state_s s_r;
  raf_state_s s_nxt;
  logic [3:0] field_hit;
  logic alarm_match;
  logic flags_rd;
  logic flags_wr;
  logic alarm_set;
  logic wd_set;
  logic pf_set;
  logic any_set;
  logic int_active;
  logic [7:0] flags_view;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm comparison, one matcher per field
  raf_field_match u_m_sec (
    .alarm_val(s_r.asec),
    .cur_val(cur_second),
    .hit(field_hit[0])
  );
  raf_field_match u_m_min (
    .alarm_val(s_r.amin),
    .cur_val(cur_minute),
    .hit(field_hit[1])
  );
  raf_field_match u_m_hour (
    .alarm_val(s_r.ahour),
    .cur_val(cur_hour),
    .hit(field_hit[2])
  );
  raf_field_match u_m_date (
    .alarm_val(s_r.adate),
    .cur_val(cur_date),
    .hit(field_hit[3])
  );

  // Match is judged once per second so one hit gives one event
  assign alarm_match = second_tick & (&field_hit);

  // Events only reach their flag while enabled
  assign alarm_set = alarm_match & alarm_int_en;
  assign wd_set = watchdog_timeout & watchdog_int_en;
  assign pf_set = supply_fail & supply_int_en;
  assign any_set = alarm_set | wd_set | pf_set;

  assign flags_rd = reg_rd & (reg_addr == ADDR_FLAGS);
  assign flags_wr = reg_wr & (reg_addr == ADDR_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    flags_view = FLAGS_RST;
    flags_view[WDF_BIT] = s_r.watchdog_expired_flag;
    flags_view[AF_BIT] = s_r.af;
    flags_view[PF_BIT] = s_r.pf;
    flags_view[OSCILLATOR_FAIL_FLAG_BIT] = s_r.oscillator_fail_flag;
    flags_view[CAL_BIT] = s_r.cal;
    flags_view[WEN_BIT] = s_r.wr_en;
    flags_view[HOLD_BIT] = s_r.rd_hold;
    unique case (reg_addr)
      ADDR_FLAGS: rd_mux = flags_view;
      ADDR_CENT: rd_mux = s_r.cent;
      ADDR_ASEC: rd_mux = s_r.asec;
      ADDR_AMIN: rd_mux = s_r.amin;
      ADDR_AHOUR: rd_mux = s_r.ahour;
      ADDR_ADATE: rd_mux = s_r.adate;
      default: rd_mux = READ_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.load = 1'b0;
    if (reg_rd)
    begin
      s_nxt.rdata = rd_mux;
    end

    // Pulse timer runs out on its own
    if (s_r.pulse_on)
    begin
      if (s_r.pulse_cnt == PULSE_LAST)
      begin
        s_nxt.pulse_on = 1'b0;
      end
      else
      begin
        s_nxt.pulse_cnt = PULSE_W'(s_r.pulse_cnt + 1'b1);
      end
    end

    // Reading flags clears the three event flags and cuts a running pulse short
    if (flags_rd)
    begin
      s_nxt.watchdog_expired_flag = 1'b0;
      s_nxt.af = 1'b0;
      s_nxt.pf = 1'b0;
      s_nxt.pulse_on = 1'b0;
    end

    // Set after clear so an event in the read cycle is not lost
    if (wd_set)
    begin
      s_nxt.watchdog_expired_flag = 1'b1;
    end
    if (alarm_set)
    begin
      s_nxt.af = 1'b1;
    end
    if (pf_set)
    begin
      s_nxt.pf = 1'b1;
    end
    if (any_set && pulse_level_select)
    begin
      s_nxt.pulse_on = 1'b1;
      s_nxt.pulse_cnt = '0;
    end

    // Delayed clear of the oscillator fail flag
    if (s_r.oclr_busy)
    begin
      if (s_r.oclr_cnt == XFER_LAST)
      begin
        s_nxt.oclr_busy = 1'b0;
        s_nxt.oscillator_fail_flag = 1'b0;
      end
      else
      begin
        s_nxt.oclr_cnt = XFER_W'(s_r.oclr_cnt + 1'b1);
      end
    end

    // Start-up window: oscillator must run by its end
    if (!s_r.por_done)
    begin
      if (s_r.por_cnt == POR_LAST)
      begin
        s_nxt.por_done = 1'b1;
        if (osc_enable && !osc_running)
        begin
          s_nxt.oscillator_fail_flag = 1'b1;
          s_nxt.oclr_busy = 1'b0;
        end
      end
      else
      begin
        s_nxt.por_cnt = POR_W'(s_r.por_cnt + 1'b1);
      end
    end

    // Counter transfer after write-enable drops
    if (s_r.xfer_busy)
    begin
      if (s_r.xfer_cnt == XFER_LAST)
      begin
        s_nxt.xfer_busy = 1'b0;
        s_nxt.load = s_r.dirty;
        s_nxt.dirty = 1'b0;
      end
      else
      begin
        s_nxt.xfer_cnt = XFER_W'(s_r.xfer_cnt + 1'b1);
      end
    end
    if (time_written && s_r.wr_en)
    begin
      s_nxt.dirty = 1'b1;
    end

    // Flags register is writable at any time
    if (flags_wr)
    begin
      s_nxt.cal = reg_wdata[CAL_BIT];
      s_nxt.wr_en = reg_wdata[WEN_BIT];
      s_nxt.rd_hold = reg_wdata[HOLD_BIT];
      if (!reg_wdata[OSCILLATOR_FAIL_FLAG_BIT] && s_r.oscillator_fail_flag && !s_r.oclr_busy)
      begin
        s_nxt.oclr_busy = 1'b1;
        s_nxt.oclr_cnt = '0;
      end
      if (s_r.wr_en && !reg_wdata[WEN_BIT])
      begin
        s_nxt.xfer_busy = 1'b1;
        s_nxt.xfer_cnt = '0;
      end
    end

    // Other registers only take writes while write-enable is set
    if (reg_wr && s_r.wr_en)
    begin
      unique case (reg_addr)
        ADDR_CENT:
        begin
          // A non-BCD digit is refused rather than stored
          if (reg_wdata[7:4] <= BCD_MAX && reg_wdata[3:0] <= BCD_MAX)
          begin
            s_nxt.cent = reg_wdata;
          end
        end
        ADDR_ASEC: s_nxt.asec = reg_wdata;
        ADDR_AMIN: s_nxt.amin = reg_wdata;
        ADDR_AHOUR: s_nxt.ahour = reg_wdata;
        ADDR_ADATE: s_nxt.adate = reg_wdata;
        default: s_nxt.cent = s_nxt.cent;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; the fail flag survives reset and is set if backup was lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.cent <= CENT_RST;
      s_r.asec <= ALARM_RST;
      s_r.amin <= ALARM_RST;
      s_r.ahour <= ALARM_RST;
      s_r.adate <= ALARM_RST;
      s_r.wr_en <= 1'b0;
      s_r.watchdog_expired_flag <= FLAGS_RST[WDF_BIT];
      s_r.af <= FLAGS_RST[AF_BIT];
      s_r.pf <= FLAGS_RST[PF_BIT];
      s_r.oscillator_fail_flag <= backup_lost | s_r.oscillator_fail_flag;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; counters stay frozen until the transfer finishes
  assign reg_rdata = s_r.rdata;
  assign freeze_counters = s_r.wr_en | s_r.xfer_busy;
  assign counters_load = s_r.load;
  assign hold_snapshot = s_r.rd_hold;
  assign cal_output_en = s_r.cal;

  // Enables gate the level so disabling a source drops the pin
  assign int_active = pulse_level_select ? s_r.pulse_on :
    ((s_r.watchdog_expired_flag & watchdog_int_en) | (s_r.af & alarm_int_en) |
     (s_r.pf & supply_int_en));
  // Open-drain mode only ever pulls low
  assign int_out = polarity_select ? int_active : 1'b0;
  assign int_oe = polarity_select ? 1'b1 : int_active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_oscillator_fail_flag_clear_req;
    flags_wr && !reg_wdata[OSCILLATOR_FAIL_FLAG_BIT] && s_r.oscillator_fail_flag && !s_r.oclr_busy;
  endsequence

  sequence s_wen_drop;
    flags_wr && s_r.wr_en && !reg_wdata[WEN_BIT];
  endsequence

  int_polarity_a: assert property (
    (polarity_select |-> int_oe && int_out == int_active) and
    (!polarity_select |-> !int_out && int_oe == int_active))
    else $error("interrupt pin drive does not follow polarity");

  pulse_hold_a: assert property (
    $rose(s_r.pulse_on) && !flags_rd |=> s_r.pulse_on)
    else $error("interrupt pulse ended early");

  alarm_all_ignore_a: assert property (
    second_tick && alarm_int_en && s_r.asec[IGNORE_BIT] &&
    s_r.amin[IGNORE_BIT] && s_r.ahour[IGNORE_BIT] &&
    s_r.adate[IGNORE_BIT] |=> s_r.af)
    else $error("ignored alarm fields blocked the match");

  century_bcd_a: assert property (
    s_r.cent[7:4] <= BCD_MAX && s_r.cent[3:0] <= BCD_MAX)
    else $error("centuries digit out of range");

  oscillator_fail_flag_clear_wait_a: assert property (
    s_oscillator_fail_flag_clear_req |=> s_r.oscillator_fail_flag [*8])
    else $error("oscillator fail flag cleared too soon");

  oscillator_fail_flag_keep_a: assert property (
    $fell(s_r.oscillator_fail_flag) |-> $past(s_r.oclr_busy) &&
    $past(s_r.oclr_cnt) == XFER_LAST)
    else $error("oscillator fail flag cleared internally");

  freeze_write_a: assert property (
    reg_wr && !s_r.wr_en && reg_addr == ADDR_ASEC |=> $stable(s_r.asec))
    else $error("alarm written while write-enable clear");

  xfer_start_a: assert property (
    s_wen_drop |=> s_r.xfer_busy && freeze_counters [*8])
    else $error("counter transfer did not start");

  load_end_a: assert property (
    counters_load |-> $past(s_r.xfer_busy) &&
    $past(s_r.xfer_cnt) == XFER_LAST)
    else $error("counter load outside transfer end");

  reset_state_a: assert property (
    $past(rst) |-> !s_r.wr_en && !s_r.watchdog_expired_flag && !s_r.af && !s_r.pf)
    else $error("write-enable or flags not zero after reset");

  flag_read_clear_a: assert property (
    flags_rd && !any_set |=> !s_r.watchdog_expired_flag && !s_r.af && !s_r.pf)
    else $error("event flags not cleared by read");

endmodule
